// ==== mld_mac_loopback.sv ====
// Loopback paths, receive ring, CRC and cable diagnostics of a 10 Mb/s MAC.
// Assumes byte streams at both network sides and host-held config inputs.
// Function
// - Mode 1: internal NRZ loop, serial interface idle
// - Mode 2: loop via serial interface, attachment unit idle
// - Mode 3: transmit on network, receive everything
// - Eight-byte receive ring, starts zero, wraps
// - CRC on: data, four CRC, count lo, hi, hi
// - CRC off: five data, count lo, hi, hi
// - Loopback: nothing stored, packet received flag clear
// - Checker test: bad 06h/02h, good 02h/01h
// - Matched loop frame, CRC generated: status 06h
// - Address mismatch: no receive indication, 02h
// - Coax cable test: 03h good, 0Eh failed
// - Thick coax without attachment unit: 53h
// - Twisted pair, no link test: always 03h
// - Auto-detect falls back to thin coax
// - coax_selected shows medium chosen by auto-detect
// - Mode 3 ring may hold foreign traffic
`timescale 1ns/1ns
module mld_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = mld_pkg::BUF_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Free slots
  output logic [$clog2(DEPTH):0] room
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("mld_fifo depth must be a power of two of at least 2");
  end
  assign in_ready = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data = mem_r[rp_r];
  assign room = (AW+1)'(DEPTH) - cnt_r;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb begin
    wp_nxt = wp_r + AW'(push);
    rp_nxt = rp_r + AW'(pop);
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  // Storage needs no reset; reads are gated by the count
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
endmodule

module mld_mac_loopback #(
  parameter int RING = mld_pkg::RING_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Configuration
  input wire logic [7:0] transmit_config,
  input wire logic [47:0] station_address,
  input wire mld_pkg::mld_medium_e medium_select,
  input wire mld_pkg::mld_cable_s cable_state,
  input wire logic [7:0] status_clear,
  // Transmit frame from host
  input wire logic tx_valid,
  output logic tx_ready,
  input wire mld_pkg::mld_byte_s tx_byte,
  // Serial network interface and attachment unit
  output logic serial_tx_valid,
  output logic mau_tx_valid,
  output mld_pkg::mld_byte_s net_tx_byte,
  // Cable receive
  input wire logic cable_rx_valid,
  output logic cable_rx_ready,
  input wire mld_pkg::mld_byte_s cable_rx_byte,
  // Packet buffer memory
  output logic buf_wr_valid,
  input wire logic buf_wr_ready,
  output mld_pkg::mld_byte_s buf_wr_byte,
  // Receive ring inspection
  input wire logic [$clog2(RING)-1:0] ring_rd_idx,
  output logic [7:0] ring_rd_data,
  // Status
  output logic [7:0] interrupt_status,
  output logic [7:0] receive_status,
  output logic [7:0] transmit_status,
  output logic coax_selected,
  output logic packet_received_flag
);
  import mld_pkg::*;
  localparam int RW = $clog2(RING);
  typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_FCS, TX_DONE} mld_tx_e;
  typedef enum logic [1:0] {RX_BODY, RX_LO, RX_HI_A, RX_HI_B} mld_rx_e;
  if (RING < 2 || (1 << RW) != RING) begin : g_chk
    $error("receive ring depth must be a power of two");
  end

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r >> 1) ^ (CRC_POLY & {32{r[0] ^ d[i]}});
    end
    return r;
  endfunction

  logic [1:0] lb;
  logic crc_inh, loop, tx_take, rx_v, buf_push, fifo_rdy, ring_we, rx_acc, rx_bad;
  mld_byte_s rx_b, out_b_r, out_b_nxt;
  logic [7:0] ring_wd, tx_stat_calc, irq_set;
  logic [$clog2(BUF_DEPTH):0] room;
  assign lb = transmit_config[TC_LB_HI:TC_LB_LO];
  assign crc_inh = transmit_config[TC_CRC_INH];
  assign loop = lb == LB_NIC || lb == LB_SERIAL;

  // Transmit engine
  mld_tx_e tx_st_r, tx_st_nxt;
  logic [31:0] tcrc_r, tcrc_nxt;
  logic [1:0] fcs_r, fcs_nxt;
  logic out_v_r, out_v_nxt, tx_ready_r, tx_ready_nxt;
  logic ser_v_r, ser_v_nxt, mau_v_r, mau_v_nxt;
  assign tx_take = tx_valid && tx_ready_r;
  always_comb begin
    tx_st_nxt = tx_st_r;
    tcrc_nxt = tcrc_r;
    fcs_nxt = fcs_r;
    out_v_nxt = 1'b0;
    out_b_nxt = out_b_r;
    unique case (tx_st_r)
      TX_IDLE: begin
        if (tx_valid) begin
          tx_st_nxt = TX_DATA;
          tcrc_nxt = CRC_INIT;
        end
      end
      TX_DATA: begin
        if (tx_take) begin
          out_v_nxt = 1'b1;
          out_b_nxt = '{last: tx_byte.last && crc_inh, data: tx_byte.data};
          tcrc_nxt = crc_byte(tcrc_r, tx_byte.data);
          fcs_nxt = 2'h0;
          if (tx_byte.last) begin
            tx_st_nxt = crc_inh ? TX_DONE : TX_FCS;
          end
        end
      end
      TX_FCS: begin
        out_v_nxt = 1'b1;
        out_b_nxt = '{last: fcs_r == FCS_LAST, data: ~tcrc_r[8*fcs_r +: 8]};
        fcs_nxt = fcs_r + 2'h1;
        if (fcs_r == FCS_LAST) begin
          tx_st_nxt = TX_DONE;
        end
      end
      TX_DONE: tx_st_nxt = TX_IDLE;
    endcase
    tx_ready_nxt = tx_st_nxt == TX_DATA;
    ser_v_nxt = out_v_nxt && lb != LB_NIC;
    mau_v_nxt = out_v_nxt && !loop;
  end
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      tx_st_r <= TX_IDLE;
      tcrc_r <= CRC_INIT;
      fcs_r <= 2'h0;
      out_v_r <= 1'b0;
      out_b_r <= '0;
      tx_ready_r <= 1'b0;
      ser_v_r <= 1'b0;
      mau_v_r <= 1'b0;
    end else begin
      tx_st_r <= tx_st_nxt;
      tcrc_r <= tcrc_nxt;
      fcs_r <= fcs_nxt;
      out_v_r <= out_v_nxt;
      out_b_r <= out_b_nxt;
      tx_ready_r <= tx_ready_nxt;
      ser_v_r <= ser_v_nxt;
      mau_v_r <= mau_v_nxt;
    end
  end
  assign tx_ready = tx_ready_r;
  assign serial_tx_valid = ser_v_r;
  assign mau_tx_valid = mau_v_r;
  assign net_tx_byte = out_b_r;

  // Receive side and ring; cable bytes are drained but dropped in modes 1 and 2
  mld_rx_e rx_st_r, rx_st_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [31:0] rcrc_r, rcrc_nxt;
  logic hit_r, hit_nxt, rx_ready_r, rx_ready_nxt;
  logic [RW-1:0] wp_r, wp_nxt;
  logic [7:0] ring_r [RING];
  logic [7:0] ring_rd_r, ring_rd_nxt;
  assign rx_v = loop ? out_v_r : cable_rx_valid && rx_ready_r;
  assign rx_b = loop ? out_b_r : cable_rx_byte;
  assign buf_push = rx_st_r == RX_BODY && rx_v && lb == LB_NORMAL && hit_r
    && cnt_r >= ADDR_BYTES;
  always_comb begin
    rx_st_nxt = rx_st_r;
    cnt_nxt = cnt_r;
    rcrc_nxt = rcrc_r;
    hit_nxt = hit_r;
    ring_we = 1'b0;
    ring_wd = rx_b.data;
    unique case (rx_st_r)
      RX_BODY: begin
        if (rx_v) begin
          ring_we = 1'b1;
          cnt_nxt = cnt_r + 16'h0001;
          rcrc_nxt = crc_byte(rcrc_r, rx_b.data);
          if (cnt_r < ADDR_BYTES && rx_b.data != station_address[8*cnt_r[2:0] +: 8]) begin
            hit_nxt = 1'b0;
          end
          if (rx_b.last) begin
            rx_st_nxt = RX_LO;
          end
        end
      end
      // Count trails the data so the ring ends lo, hi, hi
      RX_LO: begin
        ring_we = 1'b1;
        ring_wd = cnt_r[7:0];
        rx_st_nxt = RX_HI_A;
      end
      RX_HI_A: begin
        ring_we = 1'b1;
        ring_wd = cnt_r[15:8];
        rx_st_nxt = RX_HI_B;
      end
      RX_HI_B: begin
        ring_we = 1'b1;
        ring_wd = cnt_r[15:8];
        rx_st_nxt = RX_BODY;
        cnt_nxt = CNT_RST;
        rcrc_nxt = CRC_INIT;
        hit_nxt = 1'b1;
      end
    endcase
    wp_nxt = wp_r + RW'(ring_we);
    // One spare slot covers the byte already in flight when ready falls
    rx_ready_nxt = loop || (rx_st_nxt == RX_BODY && room > 1);
    ring_rd_nxt = ring_r[ring_rd_idx];
  end
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rx_st_r <= RX_BODY;
      cnt_r <= CNT_RST;
      rcrc_r <= CRC_INIT;
      hit_r <= 1'b1;
      rx_ready_r <= 1'b0;
      wp_r <= '0;
      ring_rd_r <= STAT_RST;
    end else begin
      rx_st_r <= rx_st_nxt;
      cnt_r <= cnt_nxt;
      rcrc_r <= rcrc_nxt;
      hit_r <= hit_nxt;
      rx_ready_r <= rx_ready_nxt;
      wp_r <= wp_nxt;
      ring_rd_r <= ring_rd_nxt;
    end
  end
  // Old bytes are overwritten; mode 3 traffic lands here too
  for (genvar g = 0; g < RING; g++) begin : g_ring
    always_ff @(posedge clk_sys) begin
      if (!nrst) begin
        ring_r[g] <= STAT_RST;
      end else if (ring_we && wp_r == RW'(g)) begin
        ring_r[g] <= ring_wd;
      end
    end
  end
  assign cable_rx_ready = rx_ready_r;
  assign ring_rd_data = ring_rd_r;

  mld_fifo #(.WIDTH($bits(mld_byte_s)), .DEPTH(BUF_DEPTH)) u_buf (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .in_valid(buf_push),
    .in_ready(fifo_rdy),
    .in_data(rx_b),
    .out_valid(buf_wr_valid),
    .out_ready(buf_wr_ready),
    .out_data(buf_wr_byte),
    .room(room)
  );

  // Status
  logic [7:0] irq_stat_r, irq_stat_nxt, rx_stat_r, rx_stat_nxt, tx_stat_r, tx_stat_nxt;
  logic coax_r, coax_nxt;
  assign rx_acc = hit_r && cnt_r >= ADDR_BYTES;
  // Generated CRC is not seen as good by the loop checker
  assign rx_bad = rcrc_r != CRC_RESIDUE || (lb != LB_NORMAL && !crc_inh);
  always_comb begin
    if (loop) begin
      tx_stat_calc = TS_OK;
    end else begin
      unique case (medium_select)
        MED_TP_NOLINK: tx_stat_calc = TS_OK;
        MED_TP_AUTO: tx_stat_calc = cable_state.tp_link_ok || cable_state.coax_ok
          ? TS_OK : TS_ABORT;
        MED_THIN_COAX: tx_stat_calc = cable_state.coax_ok ? TS_OK : TS_ABORT;
        MED_THICK_COAX: tx_stat_calc = !cable_state.mau_present ? TS_NO_MAU
          : cable_state.coax_ok ? TS_OK : TS_ABORT;
      endcase
    end
    irq_set = STAT_RST;
    rx_stat_nxt = rx_stat_r;
    tx_stat_nxt = tx_stat_r;
    if (tx_st_r == TX_DONE) begin
      irq_set[tx_stat_calc[0] ? IS_TX_OK : IS_TX_ERR] = 1'b1;
      tx_stat_nxt = tx_stat_calc;
    end
    if (rx_st_r == RX_HI_B && rx_acc) begin
      if (rx_bad) begin
        irq_set[IS_RX_ERR] = 1'b1;
      end else if (lb == LB_NORMAL) begin
        irq_set[IS_RX_OK] = 1'b1;
      end
      rx_stat_nxt = rx_bad ? RS_CRC_ERR : RS_GOOD;
    end
    // A new event outweighs a clear in the same cycle
    irq_stat_nxt = (irq_stat_r & ~status_clear) | irq_set;
    coax_nxt = medium_select == MED_TP_AUTO ? !cable_state.tp_link_ok
      : medium_select == MED_THIN_COAX;
  end
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      irq_stat_r <= STAT_RST;
      rx_stat_r <= STAT_RST;
      tx_stat_r <= STAT_RST;
      coax_r <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      rx_stat_r <= rx_stat_nxt;
      tx_stat_r <= tx_stat_nxt;
      coax_r <= coax_nxt;
    end
  end
  assign interrupt_status = irq_stat_r;
  assign receive_status = rx_stat_r;
  assign transmit_status = tx_stat_r;
  assign coax_selected = coax_r;
  assign packet_received_flag = irq_stat_r[IS_RX_OK];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  nic_no_serial_a: assert property (lb == LB_NIC && $past(lb) == LB_NIC |-> !ser_v_r)
    else $error("serial interface driven in mode 1");
  serial_no_mau_a: assert property (lb == LB_SERIAL |=> lb != LB_SERIAL || !mau_v_r)
    else $error("attachment unit driven in mode 2");
  cable_tx_a: assert property (out_v_nxt && lb == LB_CABLE |=> mau_v_r && ser_v_r)
    else $error("mode 3 byte not sent to network");
  ring_wrap_a: assert property (ring_we |=> wp_r == $past(wp_r) + RW'(1))
    else $error("ring pointer did not advance");
  fcs_order_a: assert property (tx_take && tx_byte.last && !crc_inh
    |=> (tx_st_r == TX_FCS) [*4] ##1 tx_st_r == TX_DONE)
    else $error("four CRC bytes not sent");
  trail_order_a: assert property (rx_st_r == RX_LO |-> ring_wd == cnt_r[7:0]
    ##1 rx_st_r == RX_HI_A ##1 rx_st_r == RX_HI_B && ring_wd == cnt_r[15:8])
    else $error("count trailer out of order");
  loop_store_a: assert property (lb != LB_NORMAL |-> !buf_push
    ##1 !irq_set[IS_RX_OK])
    else $error("loopback frame stored");
  // Receive ready leaves one slot spare, so a push never meets a full buffer
  buf_no_drop_a: assert property (buf_push |-> fifo_rdy)
    else $error("stored byte dropped at full buffer");
  crc_bad_a: assert property (rx_st_r == RX_HI_B && rx_acc && rx_bad
    |=> irq_stat_r[IS_RX_ERR] && rx_stat_r == RS_CRC_ERR)
    else $error("bad CRC not reported");
  addr_miss_a: assert property (rx_st_r == RX_HI_B && !rx_acc
    |=> $stable(rx_stat_r) && !irq_stat_r[IS_RX_ERR] || $past(irq_stat_r[IS_RX_ERR]))
    else $error("rejected frame reported");
  thick_nomau_a: assert property (tx_st_r == TX_DONE && lb == LB_CABLE
    && medium_select == MED_THICK_COAX && !cable_state.mau_present
    |=> transmit_status == TS_NO_MAU)
    else $error("missing attachment unit not reported");
  tp_nolink_a: assert property (tx_st_r == TX_DONE && medium_select == MED_TP_NOLINK
    |=> transmit_status == TS_OK)
    else $error("twisted pair without link test not ok");
  auto_coax_a: assert property ((medium_select == MED_TP_AUTO
    && !cable_state.tp_link_ok) [*2] |-> coax_selected)
    else $error("auto-detect did not pick coax");
  cover property (rx_st_r == RX_HI_B && rx_acc && !rx_bad && loop);
  cover property (tx_st_r == TX_DONE && lb == LB_CABLE && !tx_stat_calc[0]);
  cover property (buf_push ##[1:20] rx_st_r == RX_HI_B && irq_set[IS_RX_OK]);
  cover property (ring_we && wp_r == RW'(RING - 1) ##1 ring_we);
endmodule

// ==== mld_pkg.sv ====
// Shared constants and types for the loopback and diagnostic MAC logic.
// Assumes one system clock; no register bus, control and status are ports.
package mld_pkg;
  localparam int RING_DEPTH = 8;
  localparam int BUF_DEPTH = 8;
  localparam int ADDR_BYTES = 6;
  localparam logic [1:0] FCS_LAST = 2'h3;
  localparam int TC_CRC_INH = 0;
  localparam int TC_LB_LO = 1;
  localparam int TC_LB_HI = 2;
  localparam logic [1:0] LB_NORMAL = 2'h0;
  localparam logic [1:0] LB_NIC = 2'h1;
  localparam logic [1:0] LB_SERIAL = 2'h2;
  localparam logic [1:0] LB_CABLE = 2'h3;
  localparam int IS_RX_OK = 0;
  localparam int IS_TX_OK = 1;
  localparam int IS_RX_ERR = 2;
  localparam int IS_TX_ERR = 3;
  localparam logic [7:0] RS_GOOD = 8'h01;
  localparam logic [7:0] RS_CRC_ERR = 8'h02;
  localparam logic [7:0] TS_OK = 8'h03;
  localparam logic [7:0] TS_ABORT = 8'h0e;
  localparam logic [7:0] TS_NO_MAU = 8'h53;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;
  typedef enum logic [1:0] {MED_TP_NOLINK, MED_TP_AUTO, MED_THIN_COAX, MED_THICK_COAX} mld_medium_e;
  typedef struct packed {logic last; logic [7:0] data;} mld_byte_s;
  typedef struct packed {logic tp_link_ok; logic coax_ok; logic mau_present;} mld_cable_s;
endpackage

// ==== mld_cable_model.sv ====
// Model of the attachment unit and cable: every byte sent to the
// attachment unit comes back on the cable receive stream.
// Assumes the MAC byte streams, all on clk_sys.
`timescale 1ns/1ns
module mld_cable_model
  import mld_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Pacing, one idle cycle after each byte when high
  input wire logic slow,
  // From the MAC
  input wire logic mau_tx_valid,
  input wire mld_pkg::mld_byte_s net_tx_byte,
  // Cable receive stream
  output logic cable_rx_valid,
  input wire logic cable_rx_ready,
  output mld_pkg::mld_byte_s cable_rx_byte
);
  mld_byte_s q[$];
  mld_byte_s last_b;
  logic gap;

  // Offer held until taken; an idle line shows the inverse of the last byte
  always @(posedge clk_sys) begin
    gap = 1'b0;
    if (!nrst) begin
      q.delete();
      last_b = '0;
    end else begin
      if (cable_rx_valid && cable_rx_ready) begin
        last_b = q.pop_front();
        gap = slow;
      end
      if (mau_tx_valid) begin
        q.push_back(net_tx_byte);
      end
    end
    cable_rx_valid <= (q.size() > 0) && !gap;
    cable_rx_byte <= ((q.size() > 0) && !gap) ? q[0] : ~last_b;
  end
endmodule

// ==== tb_mld_mac_loopback.sv ====
// Self-checking bench for the loopback and diagnostic MAC block.
// Assumes the cable model on the network side; host driven by tasks.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin \
  comparisons++; \
  if ((got) !== (ex)) begin \
    err_count++; \
    $display("unexpected %s: expected %0h seen %0h", nm, ex, got); \
  end \
end
module tb_mld_mac_loopback;
  import mld_pkg::*;
  localparam logic [47:0] STA = 48'h0a1b2c3d4e5f;
  logic clk_sys, nrst, tx_valid, tx_ready, serial_tx_valid, mau_tx_valid;
  logic cable_rx_valid, cable_rx_ready, buf_wr_valid, buf_wr_ready, slow;
  logic coax_selected, packet_received_flag;
  logic [7:0] transmit_config, status_clear, ring_rd_data;
  logic [7:0] interrupt_status, receive_status, transmit_status;
  logic [47:0] station_address;
  logic [2:0] ring_rd_idx;
  mld_medium_e medium_select;
  mld_cable_s cable_state;
  mld_byte_s tx_byte, net_tx_byte, cable_rx_byte, buf_wr_byte;
  int err_count = 0;
  int comparisons = 0;
  int ser_n, mau_n, cyc;
  logic stalled;
  logic [7:0] bufq[$];
  logic [7:0] frm[$];

  mld_mac_loopback #(.RING(8)) i_mld_mac_loopback (.clk_sys(clk_sys), .nrst(nrst),
    .transmit_config(transmit_config), .station_address(station_address),
    .medium_select(medium_select), .cable_state(cable_state), .status_clear(status_clear),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte),
    .serial_tx_valid(serial_tx_valid), .mau_tx_valid(mau_tx_valid), .net_tx_byte(net_tx_byte),
    .cable_rx_valid(cable_rx_valid), .cable_rx_ready(cable_rx_ready),
    .cable_rx_byte(cable_rx_byte), .buf_wr_valid(buf_wr_valid),
    .buf_wr_ready(buf_wr_ready), .buf_wr_byte(buf_wr_byte), .ring_rd_idx(ring_rd_idx),
    .ring_rd_data(ring_rd_data), .interrupt_status(interrupt_status),
    .receive_status(receive_status), .transmit_status(transmit_status),
    .coax_selected(coax_selected), .packet_received_flag(packet_received_flag));

  mld_cable_model i_mld_cable_model (.clk_sys(clk_sys), .nrst(nrst), .slow(slow),
    .mau_tx_valid(mau_tx_valid), .net_tx_byte(net_tx_byte),
    .cable_rx_valid(cable_rx_valid), .cable_rx_ready(cable_rx_ready),
    .cable_rx_byte(cable_rx_byte));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Traffic counters; ceiling is several times the planned run
  always @(posedge clk_sys) begin
    cyc++;
    if (serial_tx_valid) ser_n++;
    if (mau_tx_valid) mau_n++;
    if (cable_rx_valid && !cable_rx_ready) stalled = 1'b1;
    if (buf_wr_valid && buf_wr_ready) bufq.push_back(buf_wr_byte.data);
    if (cyc == 8000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  function automatic logic [31:0] crc_of(input logic [7:0] b[$]);
    logic [31:0] r;
    r = CRC_INIT;
    foreach (b[i]) begin
      r = r ^ {24'h000000, b[i]};
      for (int k = 0; k < 8; k++) r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Reset per scenario keeps the ring pointer and statuses known
  // Host bus width setup has no port on this block
  task automatic run(input logic [7:0] tc, input int npay, input bit app, input bit bad);
    logic [31:0] c;
    int n;
    transmit_config = tc;
    @(negedge clk_sys);
    nrst = 1'b0;
    repeat (10) @(negedge clk_sys);
    nrst = 1'b1;
    ser_n = 0;
    mau_n = 0;
    stalled = 1'b0;
    bufq.delete();
    frm.delete();
    for (int i = 0; i < 6; i++) frm.push_back(STA[8*i +: 8]);
    for (int i = 0; i < npay; i++) frm.push_back(8'h5a ^ 8'(i * 37));
    c = ~crc_of(frm);
    for (int i = 0; i < 4 && app; i++) frm.push_back(c[8*i +: 8]);
    if (bad) frm[6] = ~frm[6];
    foreach (frm[i]) begin
      tx_byte = '{last: (i == frm.size() - 1), data: frm[i]};
      tx_valid = 1'b1;
      n = 0;
      while (tx_ready !== 1'b1 && n < 20) begin
        @(negedge clk_sys);
        n++;
      end
      @(negedge clk_sys);
    end
    tx_valid = 1'b0;
    n = 0;
    while (!(interrupt_status[IS_TX_OK] === 1'b1 || interrupt_status[IS_TX_ERR] === 1'b1)
           && n < 60) begin
      @(negedge clk_sys);
      n++;
    end
    repeat (30) @(negedge clk_sys);
  endtask

  // Ring holds the last eight writes: frame, CRC if generated, count lo, hi, hi
  task automatic check_ring(input bit gen);
    logic [7:0] w[$];
    logic [7:0] ex[8];
    logic [31:0] c;
    logic [15:0] cnt;
    w = frm;
    c = ~crc_of(frm);
    for (int i = 0; i < 4 && gen; i++) w.push_back(c[8*i +: 8]);
    cnt = 16'(w.size());
    w.push_back(cnt[7:0]);
    w.push_back(cnt[15:8]);
    w.push_back(cnt[15:8]);
    foreach (w[i]) ex[i % 8] = w[i];
    for (int i = 0; i < 8; i++) begin
      ring_rd_idx = 3'(i);
      @(negedge clk_sys);
      `CHK("ring byte", ex[i], ring_rd_data)
    end
  endtask

  task automatic t_nic_good();
    run(8'h03, 3, 1, 0);
    `CHK("serial bytes", 0, ser_n)
    `CHK("mau bytes", 0, mau_n)
    `CHK("irq good", 8'h02, interrupt_status)
    `CHK("rx stat good", RS_GOOD, receive_status)
    `CHK("rx flag", 1'b0, packet_received_flag)
    check_ring(0);
  endtask

  task automatic t_serial_bad();
    run(8'h05, 5, 1, 1);
    `CHK("serial bytes", frm.size(), ser_n)
    `CHK("mau bytes", 0, mau_n)
    `CHK("irq bad", 8'h06, interrupt_status)
    `CHK("rx stat bad", RS_CRC_ERR, receive_status)
    `CHK("rx flag", 1'b0, packet_received_flag)
    check_ring(0);
  endtask

  task automatic t_crc_gen();
    run(8'h04, 6, 0, 0);
    `CHK("serial bytes", frm.size() + 4, ser_n)
    `CHK("irq match", 8'h06, interrupt_status)
    `CHK("rx stat match", RS_CRC_ERR, receive_status)
    check_ring(1);
    station_address = STA ^ 48'h000000000100;
    run(8'h04, 4, 0, 0);
    `CHK("irq miss", 8'h02, interrupt_status)
    `CHK("rx stat miss", STAT_RST, receive_status)
    station_address = STA;
  endtask

  // Ring not compared in cable mode: foreign traffic may land there
  task automatic t_cable();
    mld_medium_e med[9] = '{MED_THIN_COAX, MED_THIN_COAX, MED_THICK_COAX, MED_THICK_COAX,
      MED_THICK_COAX, MED_TP_NOLINK, MED_TP_AUTO, MED_TP_AUTO, MED_TP_AUTO};
    logic [2:0] cab[9] = '{3'h3, 3'h1, 3'h3, 3'h1, 3'h2, 3'h0, 3'h4, 3'h2, 3'h0};
    logic [7:0] tstat[9] = '{8'h03, 8'h0e, 8'h03, 8'h0e, 8'h53, 8'h03, 8'h03, 8'h03, 8'h0e};
    logic cx[9] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 9; i++) begin
      medium_select = med[i];
      cable_state = cab[i];
      run(8'h06, 4, 0, 0);
      `CHK("tx stat", tstat[i], transmit_status)
      `CHK("coax sel", cx[i], coax_selected)
      `CHK("mau bytes", frm.size() + 4, mau_n)
      `CHK("rx stat cable", RS_CRC_ERR, receive_status)
    end
  endtask

  // Buffer stalls first, so the cable stream must be refused, then drain
  task automatic t_normal();
    medium_select = MED_TP_NOLINK;
    slow = 1'b1;
    buf_wr_ready = 1'b0;
    run(8'h00, 10, 0, 0);
    `CHK("cable refused", 1'b1, stalled)
    buf_wr_ready = 1'b1;
    repeat (80) @(negedge clk_sys);
    `CHK("buf bytes", frm.size() - 2, bufq.size())
    for (int i = 6; i < frm.size(); i++) `CHK("buf byte", frm[i], bufq[i - 6])
    `CHK("serial bytes", frm.size() + 4, ser_n)
    `CHK("irq normal", 8'h03, interrupt_status)
    `CHK("rx stat normal", RS_GOOD, receive_status)
    `CHK("rx flag", 1'b1, packet_received_flag)
    status_clear = 8'hff;
    @(negedge clk_sys);
    status_clear = 8'h00;
    @(negedge clk_sys);
    `CHK("irq cleared", STAT_RST, interrupt_status)
    slow = 1'b0;
  endtask

  initial begin
    nrst = 1'b0;
    slow = 1'b0;
    transmit_config = 8'h00;
    station_address = STA;
    medium_select = MED_TP_NOLINK;
    cable_state = 3'h0;
    status_clear = 8'h00;
    tx_valid = 1'b0;
    tx_byte = '0;
    buf_wr_ready = 1'b1;
    ring_rd_idx = 3'h0;
    cyc = 0;
    t_nic_good();
    t_serial_bad();
    t_crc_gen();
    t_cable();
    t_normal();
    print_verdict();
  end
endmodule
